// ### hdl/fmsp_pkg.sv
// fan motor sequencer and protection: shared constants, types and helpers
// assumes a 50 MHz system clock and 12-bit offset-binary adc codes
`default_nettype none
package fmsp_pkg;

    // time base
    localparam int CLK_PERIOD_NS = 20;
    localparam int CTRL_TICK_MS  = 1;
    localparam int PROT_TICK_US  = 125;
    localparam int CTRL_TICK_CYC = CTRL_TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROT_TICK_CYC = PROT_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam logic [2:0] BOOT_TICKS = 3'h5;

    // speed thresholds in rpm
    localparam logic [8:0] SWITCH_RPM_DEF = 9'h041;
    localparam logic [8:0] ID_OFF_RPM_DEF = 9'h055;

    // adc scaling: current full scale is the trip level, bus 0..fff = 0..300 V
    localparam logic [11:0] ADC_MID = 12'h800;
    localparam logic [11:0] OC_HI   = 12'hfff;
    localparam logic [11:0] OC_LO   = 12'h000;
    localparam logic [11:0] OV_CODE = 12'hfff;
    localparam logic [11:0] UV_CODE = 12'h2ab;

    // gate pattern: [5:3] high side, [2:0] low side
    localparam logic [5:0] GATE_NONE     = 6'h00;
    localparam logic [5:0] GATE_LOW_SIDE = 6'h07;
    localparam logic [5:0] GATE_ALL      = 6'h3f;

    // pick-up arithmetic, q12 coefficients, 16-bit angle (10000h = 360 deg)
    localparam logic [16:0] COEF_A_U   = 17'h01399;
    localparam logic [16:0] COEF_B_U   = 17'h00b50;
    localparam logic [16:0] COEF_B_W   = 17'h016a1;
    localparam logic [15:0] ANG_HALF   = 16'h8000;
    localparam logic [15:0] ANG_OFS120 = 16'h5555;
    localparam logic [15:0] BEMF_RECIP = 16'h0100;
    localparam logic [3:0]  CORDIC_LAST = 4'hf;

    // power factor stage: own 60 kHz period, independent of the inverter
    localparam logic [9:0] PFC_PERIOD_CYC = 10'h341;
    localparam logic [9:0] PFC_MAX_ON     = 10'h2ee;

    localparam logic [1:0] MODE_CODE_STOP  = 2'h0;
    localparam logic [1:0] MODE_CODE_RUN   = 2'h1;
    localparam logic [1:0] MODE_CODE_ERROR = 2'h2;

    typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_ERROR} fmsp_mode_t;
    typedef enum logic [1:0] {EV_STOP, EV_RUN, EV_ERROR, EV_RESET} fmsp_event_t;
    typedef enum logic [1:0] {PH_IDLE, PH_BOOT, PH_OPEN, PH_VECTOR} fmsp_phase_t;

    typedef struct packed {
        logic [11:0] iu;
        logic [11:0] iv;
        logic [11:0] iw;
        logic [11:0] vdc;
    } fmsp_adc_t;

    typedef struct packed {
        logic [11:0] vuv;
        logic [11:0] vwu;
    } fmsp_line_t;

    typedef struct packed {
        logic [15:0] angle;
        logic [15:0] speed_mag;
        logic [15:0] speed_delta;
        logic        dir_ccw;
        logic [15:0] bemf_volt;
        logic        valid;
    } fmsp_pickup_t;

    function automatic logic [15:0] atan_lut(input logic [3:0] i);
        case (i)
            4'h0:    atan_lut = 16'h2000;
            4'h1:    atan_lut = 16'h12e4;
            4'h2:    atan_lut = 16'h09fb;
            4'h3:    atan_lut = 16'h0511;
            4'h4:    atan_lut = 16'h028b;
            4'h5:    atan_lut = 16'h0146;
            4'h6:    atan_lut = 16'h00a3;
            4'h7:    atan_lut = 16'h0051;
            4'h8:    atan_lut = 16'h0029;
            4'h9:    atan_lut = 16'h0014;
            4'ha:    atan_lut = 16'h000a;
            4'hb:    atan_lut = 16'h0005;
            4'hc:    atan_lut = 16'h0003;
            4'hd:    atan_lut = 16'h0001;
            4'he:    atan_lut = 16'h0001;
            default: atan_lut = 16'h0000;
        endcase
    endfunction

    function automatic logic over_current(input logic [11:0] c);
        over_current = (c >= OC_HI) || (c <= OC_LO);
    endfunction

    function automatic logic [12:0] adc_signed(input logic [11:0] c);
        adc_signed = {1'b0, c} - {1'b0, ADC_MID};
    endfunction

endpackage
`default_nettype wire

// ### hdl/fmsp_pickup.sv
// coasting-motor pick-up: angle, speed and back-emf from two line voltages
// assumes line codes are stable for the 17 cycles after start
`timescale 1ns/10ps
`default_nettype none
module fmsp_pickup import fmsp_pkg::*; (
    input  wire logic         mclk,     // system clock
    input  wire logic         sys_rst,  // sync reset, high
    input  wire logic         start,    // one-cycle measurement request
    input  wire fmsp_line_t   line,     // u-v and w-u line voltage codes
    output var  fmsp_pickup_t result    // last completed estimate
);

    logic signed [19:0] x_r;
    logic signed [19:0] y_r;
    logic        [15:0] z_r;
    logic        [3:0]  it_r;
    logic               busy_r;
    logic        [15:0] prev_ang_r;
    logic signed [12:0] u_s;
    logic signed [12:0] w_s;
    logic signed [31:0] pa;
    logic signed [31:0] pb;
    logic signed [19:0] dx;
    logic signed [19:0] dy;
    logic        [35:0] spd;
    logic        [15:0] ang_true;

    // alpha/beta from the two line voltages
    always_comb begin
        u_s = adc_signed(line.vuv);
        w_s = adc_signed(line.vwu);
        pa  = u_s * $signed(COEF_A_U);
        pb  = -(u_s * $signed(COEF_B_U) + w_s * $signed(COEF_B_W));
        dx  = x_r >>> it_r;
        dy  = y_r >>> it_r;
        spd = 36'(x_r[19:0]) * 36'(BEMF_RECIP);
        ang_true = z_r - ANG_OFS120;
    end

    // vectoring rotation drives q to zero, so x ends as |d,q|
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            x_r    <= '0;
            y_r    <= '0;
            z_r    <= '0;
            it_r   <= '0;
            busy_r <= 1'b0;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
            it_r   <= '0;
            // left half-plane: pre-rotate by 180 deg
            if (pa[31]) begin
                x_r <= -pa[31:12];
                y_r <= -pb[31:12];
                z_r <= ANG_HALF;
            end else begin
                x_r <= pa[31:12];
                y_r <= pb[31:12];
                z_r <= '0;
            end
        end else if (busy_r) begin
            // arctangent of beta over alpha accumulates in z
            if (!y_r[19]) begin
                x_r <= x_r + dy;
                y_r <= y_r - dx;
                z_r <= z_r + atan_lut(it_r);
            end else begin
                x_r <= x_r - dy;
                y_r <= y_r + dx;
                z_r <= z_r - atan_lut(it_r);
            end
            it_r <= it_r + 4'h1;
            if (it_r == CORDIC_LAST) begin
                busy_r <= 1'b0;
            end
        end
    end

    // one start per control tick while the inverter is off, so the raw angle change is speed per tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result     <= '0;
            prev_ang_r <= '0;
        end else if (busy_r && it_r == CORDIC_LAST) begin
            result.angle       <= ang_true;
            result.speed_mag   <= spd[23:8];
            result.speed_delta <= z_r - prev_ang_r;
            result.dir_ccw     <= (z_r - prev_ang_r) >= ANG_HALF;
            // inverter voltage set equal to measured back-emf
            result.bemf_volt   <= x_r[15:0];
            result.valid       <= 1'b1;
            prev_ang_r         <= z_r;
        end
    end

endmodule
`default_nettype wire

// ### hdl/fmsp_top.sv
// fan motor sequencer with start-up phases, pick-up catch, pfc and trips
// assumes adc codes arrive synchronous to mclk; pwm/vector math lives outside
// Functional notes
// - run event: stop goes run, error stays
// - stop event: run goes stop, error stays
// - error event forces error from stop/run
// - reset: error->stop, stop->stop, run->error
// - five 1 ms boot-charge ticks before open loop
// - open loop to vector at switchover speed
// - direct-axis current off at second threshold
// - phase overcurrent checked each 125 us, trips
// - bus overvoltage checked each 125 us, trips
// - bus undervoltage checked each 125 us, trips
// - restart output voltage equals measured back-emf
// - alpha/beta from line voltages, angle by arctangent
// - speed from d/q magnitude over scaled constant
// - angle change per tick gives speed, direction
// - angle for vector control less 120 degrees
// - pfc continuous-mode single switch, shunt sensed
// - pfc timing independent of inverter timing
// - emergency stop drops all six gate outputs
`timescale 1ns/10ps
`default_nettype none
module fmsp_top import fmsp_pkg::*; #(
    parameter int unsigned MS_CYC     = CTRL_TICK_CYC,
    parameter int unsigned PROT_CYC   = PROT_TICK_CYC,
    parameter logic [8:0]  SWITCH_RPM = SWITCH_RPM_DEF,
    parameter logic [8:0]  ID_OFF_RPM = ID_OFF_RPM_DEF
) (
    input  wire logic         mclk,             // 50 MHz clock
    input  wire logic         sys_rst,          // sync reset, high
    input  wire logic         run_request_flag, // 1 start, 0 stop
    input  wire logic         fault_reset_req,  // reset event request
    input  wire fmsp_adc_t    adc,              // phase currents, bus voltage
    input  wire fmsp_line_t   line,             // line voltage codes
    input  wire logic [8:0]   rotor_speed_rpm,  // estimator speed
    input  wire logic [11:0]  pfc_current_code, // pfc shunt current
    input  wire logic [11:0]  pfc_current_ref,  // pfc peak reference
    output logic [1:0]        mode_code_r,      // 0 stop, 1 run, 2 error
    output var fmsp_phase_t   drive_phase_r,    // start-up phase
    output logic [5:0]        gate_enable_r,    // six gate enables
    output logic              id_inject_r,      // d-axis start current on
    output logic              trip_oc_r,        // sticky overcurrent
    output logic              trip_ov_r,        // sticky overvoltage
    output logic              trip_uv_r,        // sticky undervoltage
    output logic [15:0]       volt_cmd_r,       // caught voltage command
    output logic [15:0]       angle_cmd_r,      // caught angle command
    output logic              pfc_gate_r,       // pfc switch drive
    output var fmsp_pickup_t  pickup_o          // pick-up estimate
);

    fmsp_mode_t  mode_r;
    fmsp_mode_t  mode_nxt;
    fmsp_event_t ev_w;
    logic [15:0] ms_cnt_r;
    logic        ms_tick_r;
    logic [12:0] prot_cnt_r;
    logic        prot_tick_r;
    logic        trip_pend_r;
    logic [2:0]  boot_cnt_r;
    logic [9:0]  pfc_cnt_r;
    logic        oc_w;
    logic        ov_w;
    logic        uv_w;
    logic        trip_now;
    logic        keep_run;
    logic        catch_ok;

    function automatic fmsp_mode_t seq_next(input fmsp_mode_t m, input fmsp_event_t e);
        seq_next = m;
        case (e)
            EV_RUN:   if (m == MODE_STOP) seq_next = MODE_RUN;
            EV_STOP:  if (m == MODE_RUN) seq_next = MODE_STOP;
            EV_ERROR: seq_next = MODE_ERROR;
            EV_RESET: seq_next = (m == MODE_RUN) ? MODE_ERROR : MODE_STOP;
            default:  seq_next = m;
        endcase
    endfunction

    function automatic logic [1:0] mode_code(input fmsp_mode_t m);
        case (m)
            MODE_RUN:   mode_code = MODE_CODE_RUN;
            MODE_ERROR: mode_code = MODE_CODE_ERROR;
            default:    mode_code = MODE_CODE_STOP;
        endcase
    endfunction

    // control and protection time bases
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ms_cnt_r  <= '0;
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == 16'(MS_CYC - 1)) begin
            ms_cnt_r  <= '0;
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r  <= ms_cnt_r + 16'h0001;
            ms_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prot_cnt_r  <= '0;
            prot_tick_r <= 1'b0;
        end else if (prot_cnt_r == 13'(PROT_CYC - 1)) begin
            prot_cnt_r  <= '0;
            prot_tick_r <= 1'b1;
        end else begin
            prot_cnt_r  <= prot_cnt_r + 13'h0001;
            prot_tick_r <= 1'b0;
        end
    end

    always_comb begin
        oc_w = over_current(adc.iu) || over_current(adc.iv)
            || over_current(adc.iw);
        ov_w = adc.vdc >= OV_CODE;
        uv_w = adc.vdc < UV_CODE;
        trip_now = prot_tick_r && (oc_w || ov_w || uv_w);
        // a trip outranks every host request in the same tick
        if (trip_pend_r || trip_now) begin
            ev_w = EV_ERROR;
        end else if (fault_reset_req) begin
            ev_w = EV_RESET;
        end else if (run_request_flag) begin
            ev_w = EV_RUN;
        end else begin
            ev_w = EV_STOP;
        end
        mode_nxt = ms_tick_r ? seq_next(mode_r, ev_w) : mode_r;
        keep_run = mode_nxt == MODE_RUN;
        catch_ok = pickup_o.valid && (pickup_o.speed_mag >= {7'h00, SWITCH_RPM});
    end

    // trip detected between ticks waits here for the next tick
    // a trip on the tick itself is posted at once, so holding it would post it twice
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trip_pend_r <= 1'b0;
        end else if (ms_tick_r) begin
            trip_pend_r <= 1'b0;
        end else if (trip_now) begin
            trip_pend_r <= 1'b1;
        end
    end

    // sticky causes; a new trip wins over the clearing reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trip_oc_r <= 1'b0;
            trip_ov_r <= 1'b0;
            trip_uv_r <= 1'b0;
        end else if (ms_tick_r && ev_w == EV_RESET && mode_r == MODE_ERROR) begin
            trip_oc_r <= prot_tick_r && oc_w;
            trip_ov_r <= prot_tick_r && ov_w;
            trip_uv_r <= prot_tick_r && uv_w;
        end else begin
            trip_oc_r <= trip_oc_r || (prot_tick_r && oc_w);
            trip_ov_r <= trip_ov_r || (prot_tick_r && ov_w);
            trip_uv_r <= trip_uv_r || (prot_tick_r && uv_w);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_r      <= MODE_STOP;
            mode_code_r <= MODE_CODE_STOP;
        end else begin
            mode_r      <= mode_nxt;
            mode_code_r <= mode_code(mode_nxt);
        end
    end

    // start-up phases; all advance only on the control tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            drive_phase_r <= PH_IDLE;
            boot_cnt_r    <= '0;
            id_inject_r   <= 1'b0;
            volt_cmd_r    <= '0;
            angle_cmd_r   <= '0;
        end else if (!keep_run) begin
            drive_phase_r <= PH_IDLE;
            boot_cnt_r    <= '0;
            id_inject_r   <= 1'b0;
            volt_cmd_r    <= '0;
            angle_cmd_r   <= '0;
        end else if (mode_r != MODE_RUN) begin
            drive_phase_r <= PH_BOOT;
            boot_cnt_r    <= '0;
        end else if (ms_tick_r) begin
            case (drive_phase_r)
                PH_BOOT: begin
                    if (boot_cnt_r == BOOT_TICKS - 3'h1) begin
                        if (catch_ok) begin
                            // coasting rotor: take over at its own emf
                            drive_phase_r <= PH_VECTOR;
                            volt_cmd_r    <= pickup_o.bemf_volt;
                            angle_cmd_r   <= pickup_o.angle;
                        end else begin
                            drive_phase_r <= PH_OPEN;
                            id_inject_r   <= 1'b1;
                        end
                    end else begin
                        boot_cnt_r <= boot_cnt_r + 3'h1;
                    end
                end
                PH_OPEN: begin
                    if (rotor_speed_rpm >= SWITCH_RPM) begin
                        drive_phase_r <= PH_VECTOR;
                    end
                    if (rotor_speed_rpm >= ID_OFF_RPM) begin
                        id_inject_r <= 1'b0;
                    end
                end
                PH_VECTOR: begin
                    if (rotor_speed_rpm >= ID_OFF_RPM) begin
                        id_inject_r <= 1'b0;
                    end
                end
                default: drive_phase_r <= PH_IDLE;
            endcase
        end
    end

    // gates drop on the edge after detection, ahead of the error tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gate_enable_r <= GATE_NONE;
        end else if (trip_now || trip_pend_r || !keep_run) begin
            gate_enable_r <= GATE_NONE;
        end else begin
            case (drive_phase_r)
                PH_BOOT:   gate_enable_r <= GATE_LOW_SIDE;
                PH_OPEN:   gate_enable_r <= GATE_ALL;
                PH_VECTOR: gate_enable_r <= GATE_ALL;
                default:   gate_enable_r <= GATE_NONE;
            endcase
        end
    end

    // pfc free-runs on its own period, never aligned to the tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pfc_cnt_r <= '0;
        end else if (pfc_cnt_r == PFC_PERIOD_CYC - 10'h001) begin
            pfc_cnt_r <= '0;
        end else begin
            pfc_cnt_r <= pfc_cnt_r + 10'h001;
        end
    end

    // peak current mode, one switch, shunt sensed current
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pfc_gate_r <= 1'b0;
        end else if (trip_now || trip_pend_r || mode_r != MODE_RUN) begin
            pfc_gate_r <= 1'b0;
        end else if (pfc_cnt_r == '0) begin
            pfc_gate_r <= 1'b1;
        end else if (pfc_current_code >= pfc_current_ref || pfc_cnt_r == PFC_MAX_ON) begin
            pfc_gate_r <= 1'b0;
        end
    end

    // measure only while the inverter is off
    fmsp_pickup u_pickup (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (ms_tick_r && mode_r != MODE_RUN),
        .line    (line),
        .result  (pickup_o)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_boot_last;
        drive_phase_r == PH_BOOT && mode_r == MODE_RUN && ms_tick_r
            && keep_run && boot_cnt_r == BOOT_TICKS - 3'h1;
    endsequence

    sequence s_boot_early;
        drive_phase_r == PH_BOOT && ms_tick_r && boot_cnt_r < BOOT_TICKS - 3'h1;
    endsequence

    a_run_from_stop: assert property (
        ms_tick_r && mode_r == MODE_STOP && ev_w == EV_RUN |=> mode_code_r == MODE_CODE_RUN)
        else $error("run event did not start from stop");
    a_error_sticks: assert property (
        ms_tick_r && mode_r == MODE_ERROR && ev_w inside {EV_RUN, EV_STOP}
            |=> mode_r == MODE_ERROR)
        else $error("error mode left on run or stop event");
    a_stop_from_run: assert property (
        ms_tick_r && mode_r == MODE_RUN && ev_w == EV_STOP
            |=> mode_r == MODE_STOP ##1 gate_enable_r == GATE_NONE)
        else $error("stop event did not stop the run");
    a_trip_posts_error: assert property (
        trip_now |-> ##[0:1] (trip_pend_r || mode_r == MODE_ERROR))
        else $error("trip not held for the tick");
    a_pending_error: assert property (
        ms_tick_r && trip_pend_r |=> mode_code_r == MODE_CODE_ERROR && !trip_pend_r)
        else $error("pending trip did not enter error");
    a_reset_paths: assert property (
        ms_tick_r && ev_w == EV_RESET
            |=> mode_r == (($past(mode_r) == MODE_RUN) ? MODE_ERROR : MODE_STOP))
        else $error("reset event went the wrong way");
    a_boot_hold: assert property (
        s_boot_early |=> drive_phase_r inside {PH_BOOT, PH_IDLE})
        else $error("boot charge ended early");
    a_boot_done: assert property (
        s_boot_last |=> drive_phase_r inside {PH_OPEN, PH_VECTOR})
        else $error("boot charge did not end after five ticks");
    a_open_switch: assert property (
        drive_phase_r == PH_OPEN && mode_r == MODE_RUN && ms_tick_r && keep_run
            && rotor_speed_rpm >= SWITCH_RPM |=> drive_phase_r == PH_VECTOR)
        else $error("no switch to vector control");
    a_id_cut: assert property (
        id_inject_r && mode_r == MODE_RUN && ms_tick_r && keep_run
            && drive_phase_r != PH_BOOT && rotor_speed_rpm >= ID_OFF_RPM |=> !id_inject_r)
        else $error("d-axis current not switched off");
    a_oc_kill: assert property (
        prot_tick_r && oc_w |=> trip_oc_r && gate_enable_r == GATE_NONE)
        else $error("overcurrent did not stop the gates");
    a_ov_kill: assert property (
        prot_tick_r && ov_w |=> trip_ov_r && gate_enable_r == GATE_NONE)
        else $error("overvoltage did not stop the gates");
    a_uv_kill: assert property (
        prot_tick_r && uv_w |=> trip_uv_r && gate_enable_r == GATE_NONE)
        else $error("undervoltage did not stop the gates");
    a_gates_idle: assert property (
        mode_r != MODE_RUN |=> gate_enable_r == GATE_NONE && !pfc_gate_r)
        else $error("gates driven outside run");

endmodule
`default_nettype wire

// ### test/fmsp_plant.sv
// plant model: inverter feedback codes and pfc shunt current
// assumes tb selects faults and coasting vectors; vector 0 is a stopped rotor
`timescale 1ns/10ps
`default_nettype none
module fmsp_plant import fmsp_pkg::*; (
    input  wire logic        mclk,     // system clock
    input  wire logic [1:0]  fault,    // 0 none, 1 oc, 2 ov, 3 uv
    input  wire logic [1:0]  coast,    // 0 still, 1 w-u only, 2 u-v only
    input  wire logic        pfc_gate, // pfc switch drive
    output var  fmsp_adc_t   adc,      // phase currents, bus voltage
    output var  fmsp_line_t  line,     // line voltage codes
    output logic [11:0]      pfc_code  // pfc shunt current
);
    always_comb begin
        adc = {ADC_MID, ADC_MID, ADC_MID, 12'h800};
        if (fault == 2'h1) adc.iu = OC_HI;
        if (fault == 2'h2) adc.vdc = OV_CODE;
        if (fault == 2'h3) adc.vdc = 12'h2aa;
        line = {ADC_MID, ADC_MID};
        if (coast == 2'h1) line.vwu = ADC_MID + 12'h400;
        if (coast == 2'h2) line.vuv = ADC_MID + 12'h400;
    end
    // inductor current ramps only while the switch conducts
    always_ff @(posedge mclk) begin
        pfc_code <= pfc_gate ? pfc_code + 12'h001 : 12'h000;
    end
endmodule
`default_nettype wire

// ### test/tb.sv
// testbench: sequencer table, trips, start-up phases, pfc
// assumes fmsp_top with shortened tick counts and the plant model
`timescale 1ns/10ps
`default_nettype none
module tb import fmsp_pkg::*; ;
    localparam int MS = 40;
    logic mclk = 1'b0, sys_rst = 1'b1, req = 1'b0, frst = 1'b0;
    logic [8:0] spd = 9'h000;
    logic [1:0] fault = 2'h0, coast = 2'h0, mode;
    logic [11:0] pcode;
    logic [5:0] gates;
    logic idi, toc, tov, tuv, pgate;
    logic [15:0] vcmd, acmd;
    fmsp_adc_t adc;
    fmsp_line_t line;
    fmsp_phase_t ph;
    fmsp_pickup_t pk;
    int n_fail = 0, checks = 0, i;
    // {run req, reset req, expected mode}
    logic [3:0] rows [8] = '{4'h9, 4'h0, 4'h4, 4'h9, 4'h6, 4'ha, 4'h2, 4'h4};
    logic [8:0] sp [4] = '{9'h040, 9'h041, 9'h054, 9'h055};
    initial forever #10 mclk = ~mclk;
    fmsp_plant fmsp_plant_inst (.mclk(mclk), .fault(fault), .coast(coast), .pfc_gate(pgate),
        .adc(adc), .line(line), .pfc_code(pcode));
    fmsp_top #(.MS_CYC(MS), .PROT_CYC(10)) fmsp_top_inst (.mclk(mclk),
        .sys_rst(sys_rst), .run_request_flag(req), .fault_reset_req(frst),
        .adc(adc), .line(line), .rotor_speed_rpm(spd), .pfc_current_code(pcode),
        .pfc_current_ref(12'h100), .mode_code_r(mode), .drive_phase_r(ph),
        .gate_enable_r(gates), .id_inject_r(idi), .trip_oc_r(toc),
        .trip_ov_r(tov), .trip_uv_r(tuv), .volt_cmd_r(vcmd),
        .angle_cmd_r(acmd), .pfc_gate_r(pgate), .pickup_o(pk));
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // angles compared on the circle, within about 0.7 deg
    task automatic chk_near(input string nm, input logic [15:0] e, g);
        checks++;
        if ($isunknown(g) || 16'(g - e + 16'h0080) > 16'h0100) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one control tick per window; checked after the tick has landed
    task automatic win(input logic r, f, input logic [8:0] s);
        @(posedge mclk);
        req <= r;
        frst <= f;
        spd <= s;
        repeat (MS - 1) @(posedge mclk);
        #1;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 chk("mode", 16'h0, mode);
        chk("gates", 16'h0, gates);
        @(posedge mclk);
        sys_rst <= 1'b0;
        req <= 1'b1;
        for (i = 0; i < 3 * MS && mode !== MODE_CODE_RUN; i++) @(posedge mclk);
        if (i >= 3 * MS) begin
            n_fail++;
            report_and_stop();
        end
        repeat (3) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            win(rows[i][3], rows[i][2], 9'h000);
            chk("mode", rows[i][1:0], mode);
        end
        for (i = 1; i < 4; i++) begin
            win(i > 1, 1'b0, 9'h000);
            fault <= 2'(i);
            win(i > 1, 1'b0, 9'h000);
            chk("trips", 16'h1 << (i - 1), {tuv, tov, toc});
            chk("gates", 16'h0, gates);
            chk("mode", MODE_CODE_ERROR, mode);
            fault <= 2'h0;
            win(1'b0, 1'b1, 9'h000);
            chk("cleared", 16'h0, {tuv, tov, toc, mode});
        end
        // pick-up: each tick measures, the result shows in the next window
        // vector 1 is -90 deg raw (150 after offset), vector 2 is -30 raw (210)
        coast <= 2'h1;
        win(1'b0, 1'b0, 9'h000);
        coast <= 2'h2;
        win(1'b0, 1'b0, 9'h000);
        chk_near("angle", 16'h6aab, pk.angle);
        chk("valid", 16'h1, pk.valid);
        coast <= 2'h1;
        win(1'b0, 1'b0, 9'h000);
        chk_near("angle", 16'h9555, pk.angle);
        chk_near("delta", 16'h2aab, pk.speed_delta);
        chk("dir", 16'h0, pk.dir_ccw);
        win(1'b1, 1'b0, 9'h000);
        chk_near("delta", 16'hd555, pk.speed_delta);
        chk("dir", 16'h1, pk.dir_ccw);
        repeat (5) win(1'b1, 1'b0, 9'h000);
        chk("catch", PH_VECTOR, ph);
        chk("volt", pk.bemf_volt, vcmd);
        chk("id", 16'h0, idi);
        chk_near("angle cmd", 16'h6aab, acmd);
        coast <= 2'h0;
        win(1'b0, 1'b0, 9'h000);
        chk("stopped", 16'h0, {vcmd, mode});
        win(1'b1, 1'b0, 9'h000);
        chk("phase", PH_BOOT, ph);
        chk("gates", GATE_LOW_SIDE, gates);
        repeat (4) win(1'b1, 1'b0, 9'h000);
        chk("phase", PH_BOOT, ph);
        win(1'b1, 1'b0, 9'h000);
        chk("phase", PH_OPEN, ph);
        chk("gates", GATE_ALL, gates);
        for (i = 0; i < 4; i++) begin
            win(1'b1, 1'b0, sp[i]);
            chk("phase", (i > 0) ? PH_VECTOR : PH_OPEN, ph);
            chk("id", i < 3, idi);
        end
        for (i = 0; i < 900 && pgate !== 1'b1; i++) @(posedge mclk);
        chk("pfc on", 16'h1, pgate);
        for (i = 0; i < 400 && pgate !== 1'b0; i++) @(posedge mclk);
        chk("pfc off", 16'h0, pgate);
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        #1 chk("rst", 16'h0, {gates, mode});
        report_and_stop();
    end
endmodule
`default_nettype wire
